/* File: rtl/acpc_pkg.sv */
// package for the pair-a convert and port control block
// assumes one 25 MHz clock and a host that drives the pins synchronously
package acpc_pkg;
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned CONV_CYCLES = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_03FF;
    localparam int unsigned SEQ_BIT = 23;
    localparam int unsigned CLOCK_SOURCE_SELECT_BIT = 11;
    localparam int unsigned RESET_MIN_NS = 50;
    localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] CONV_LAST = 5'h0F;

    typedef enum logic [1:0]
    {
        ACPC_IDLE = 2'b00,
        ACPC_CONV = 2'b01,
        ACPC_PPD = 2'b10,
        ACPC_DONE = 2'b11
    } acpc_state_t;

    typedef struct packed
    {
        logic select_n;
        logic read_n;
        logic byte_mode;
        logic high_byte_first;
    } acpc_bus_ctl_t;

    typedef struct packed
    {
        logic [15:0] data;
        logic ch;
    } acpc_word_t;
endpackage

/* File: rtl/acpc_top.sv */
// conversion start, power modes, reset and parallel result port for pair a
// assumes host pins are synchronous to mclk and results arrive from the sar cores
// Behaviour
// - hardware mode: start rising edge samples both pair-a inputs together
// - start dropping before conversion ends puts pair a in partial power-down
// - software mode with sequential bit set: start converts pair a only
// - standby low powers everything down including clock and reference
// - active-high reset aborts the pair-a conversion
// - reset reloads the configuration word with its default value
// - word mode drives full sixteen-bit result in one access
// - byte mode uses upper eight lines, two accesses, order from high_byte_first
// - hardware mode: range pin low selects four-times-reference input range
// - software mode with clock select bit set: range pin is clock input
// - parallel interface enabled only while select is low
// - data bus driven only while read strobe is low
`timescale 1ns/1ps
module acpc_top
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // control pins
    input wire logic pair_a_convert_start,
    input wire logic standby_n,
    input wire logic dev_reset,
    input wire logic config_source_select,
    input wire logic interface_select,
    input wire logic range_or_ext_clock,
    // configuration word load
    input wire logic cfg_we,
    input wire logic [31:0] cfg_wdata,
    // parallel bus control
    input wire acpc_pkg::acpc_bus_ctl_t bus_ctl,
    // results from converter cores
    input wire logic [15:0] core_result0,
    input wire logic [15:0] core_result1,
    // result bus
    output logic [15:0] result_bus_o,
    output logic [15:0] result_bus_oe,
    // status and analog controls
    output logic sample_pair_a,
    output logic pair_a_ppd,
    output logic busy,
    output logic powered_down,
    output logic range_4vref,
    output logic ext_clock_sel,
    output logic [31:0] configuration_word
);
    import acpc_pkg::*;

    // two-stage synchronisers; stage one feeds stage two only
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic start_d_r;
    acpc_state_t state_r;
    acpc_state_t state_nxt;
    logic [4:0] cnt_r;
    logic [31:0] cfg_r;
    logic [15:0] res0_r;
    logic [15:0] res1_r;
    // buffer of two result words between converter and bus
    acpc_word_t buf_q[2];
    logic [1:0] buf_v_r;
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic byte_half_r;
    logic sel_d_r;
    logic rd_d_r;

    wire start_s = sync2_r[0];
    wire standby_n_s = sync2_r[1];
    wire rst_s = sync2_r[2];
    wire start_rise = start_s && !start_d_r;
    wire sw_mode = config_source_select;
    wire seq_mode = cfg_r[SEQ_BIT];
    // hardware mode or sequential software mode may start pair a
    wire start_ok = !sw_mode || seq_mode;
    wire abort = rst_s || !standby_n_s;
    wire conv_end = (state_r == ACPC_CONV) && (cnt_r == CONV_LAST);
    wire in_valid = conv_end && start_s;
    wire in_ready = !(buf_v_r[0] && buf_v_r[1]);
    wire bus_en = !interface_select && !bus_ctl.select_n;
    wire drive = bus_en && !bus_ctl.read_n;
    wire rd_end = sel_d_r && rd_d_r && !(bus_en && !bus_ctl.read_n);
    wire out_valid = buf_v_r[rd_ptr_r];
    wire word_done = !bus_ctl.byte_mode || byte_half_r;
    wire out_ready = rd_end && word_done;
    wire [15:0] head = buf_q[rd_ptr_r].data;
    wire first_hi = bus_ctl.high_byte_first ^ byte_half_r;
    wire [7:0] byte_out = first_hi ? head[15:8] : head[7:0];
    wire [15:0] bus_val = bus_ctl.byte_mode ? {byte_out, 8'h00} : head;
    wire [15:0] bus_oe = !drive ? 16'h0000 : (bus_ctl.byte_mode ? 16'hFF00 : 16'hFFFF);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ACPC_IDLE:
                if (start_rise && start_ok)
                    state_nxt = ACPC_CONV;
            ACPC_CONV:
                if (!start_s)
                    state_nxt = ACPC_PPD;
                else if (cnt_r == CONV_LAST)
                    state_nxt = ACPC_DONE;
            ACPC_PPD:
                if (start_rise && start_ok)
                    state_nxt = ACPC_CONV;
            ACPC_DONE:
                if (!start_s)
                    state_nxt = ACPC_IDLE;
            default:
                state_nxt = ACPC_IDLE;
        endcase
        if (abort)
            state_nxt = ACPC_IDLE;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            // standby stage idles high so leaving reset is not a false power-down
            sync1_r <= 3'h2;
            sync2_r <= 3'h2;
            start_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {dev_reset, standby_n, pair_a_convert_start};
            sync2_r <= sync1_r;
            start_d_r <= start_s;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_r <= ACPC_IDLE;
            cnt_r <= 5'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= (state_nxt == ACPC_CONV && state_r == ACPC_CONV) ? cnt_r + 5'h01 : 5'h00;
        end
    end

    // reset pin reloads the word; software write otherwise
    always_ff @(posedge mclk)
    begin
        if (!rstn || rst_s)
            cfg_r <= CFG_RESET;
        else if (cfg_we)
            cfg_r <= cfg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (start_rise && start_ok && state_r != ACPC_CONV)
        begin
            res0_r <= core_result0;
            res1_r <= core_result1;
        end
    end

    // a full buffer drops a finished pair rather than stalling the sar
    always_ff @(posedge mclk)
    begin
        if (!rstn || rst_s)
        begin
            buf_v_r <= 2'b00;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            byte_half_r <= 1'b0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                buf_q[wr_ptr_r] <= '{data: res0_r, ch: 1'b0};
                wr_ptr_r <= !wr_ptr_r;
            end
            if (rd_end && out_valid)
                byte_half_r <= bus_ctl.byte_mode ? !byte_half_r : 1'b0;
            if (out_ready && out_valid)
                rd_ptr_r <= !rd_ptr_r;
            buf_v_r <= (buf_v_r
                | ((in_valid && in_ready) ? (2'b01 << wr_ptr_r) : 2'b00))
                & ~((out_ready && out_valid) ? (2'b01 << rd_ptr_r) : 2'b00);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            sel_d_r <= 1'b0;
            rd_d_r <= 1'b0;
            result_bus_o <= 16'h0000;
            result_bus_oe <= 16'h0000;
            sample_pair_a <= 1'b0;
            pair_a_ppd <= 1'b0;
            busy <= 1'b0;
            powered_down <= 1'b0;
            range_4vref <= 1'b0;
            ext_clock_sel <= 1'b0;
            configuration_word <= CFG_RESET;
        end
        else
        begin
            sel_d_r <= bus_en;
            rd_d_r <= drive;
            result_bus_o <= drive ? bus_val : 16'h0000;
            result_bus_oe <= bus_oe;
            sample_pair_a <= state_nxt == ACPC_CONV && state_r != ACPC_CONV;
            pair_a_ppd <= state_nxt == ACPC_PPD;
            busy <= state_nxt == ACPC_CONV;
            powered_down <= !standby_n_s;
            range_4vref <= !sw_mode && !range_or_ext_clock;
            ext_clock_sel <= sw_mode && cfg_r[CLOCK_SOURCE_SELECT_BIT];
            configuration_word <= cfg_r;
        end
    end
endmodule

/* File: verification/acpc_checker_assertions.sv */
// checker on the acpc_top pins
// assumes a bind inside acpc_top, one clock
`timescale 1ns/1ps
module acpc_checker
(
    // clock
    input logic mclk,
    input logic rstn,
    // pins
    input logic pair_a_convert_start,
    input logic standby_n,
    input logic dev_reset,
    input logic config_source_select,
    input acpc_pkg::acpc_bus_ctl_t bus_ctl,
    // outputs
    input logic [15:0] result_bus_oe,
    input logic sample_pair_a,
    input logic pair_a_ppd,
    input logic busy,
    input logic powered_down,
    input logic [31:0] configuration_word
);
    import acpc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    start_take_a: assert property (
        $rose(pair_a_convert_start) && !config_source_select && standby_n && !busy
        |-> ##[2:5] sample_pair_a) else $error("start");
    pulse_once_a: assert property (sample_pair_a |=> !sample_pair_a) else $error("pulse");
    busy_follow_a: assert property (sample_pair_a |-> ##[0:1] busy) else $error("busy");
    ppd_cause_a: assert property (
        $rose(pair_a_ppd) |-> $past(busy) || $past(busy, 2)) else $error("ppd");
    standby_down_a: assert property (!standby_n [*4] |-> powered_down) else $error("standby_n");
    reset_reload_a: assert property (
        dev_reset [*2] |-> ##[1:4] !busy && configuration_word == CFG_RESET) else $error("rst");
    bus_release_a: assert property (
        (bus_ctl.read_n || bus_ctl.select_n) [*2] |-> result_bus_oe == 16'h0000)
        else $error("release");
    width_sel_a: assert property (
        result_bus_oe != 16'h0000 |-> result_bus_oe == (bus_ctl.byte_mode ? 16'hFF00 : 16'hFFFF))
        else $error("width");
endmodule

/* File: verification/acpc_host.sv */
// host model: pair-a start, pin reset, read strobes
// assumes the bench clock; pins move on falling edges
`timescale 1ns/1ps
module acpc_host
(
    // clock
    input logic mclk,
    // pins
    output logic pair_a_convert_start = 1'b0,
    output logic dev_reset = 1'b0,
    output acpc_pkg::acpc_bus_ctl_t bus_ctl = 4'hC,
    input logic [15:0] result_bus_o,
    input logic [15:0] result_bus_oe
);
    import acpc_pkg::*;
    task automatic conv(input int h);
        pair_a_convert_start = 1'b1;
        repeat (h) @(negedge mclk);
        pair_a_convert_start = 1'b0;
        repeat (6) @(negedge mclk);
    endtask
    // strobes stay low two cycles so the word is settled when taken
    task automatic rd(input logic bm, hb, output logic [15:0] d);
        bus_ctl = {2'b00, bm, hb};
        repeat (2) @(negedge mclk);
        d = result_bus_o;
        bus_ctl = {2'b11, bm, hb};
        repeat (2) @(negedge mclk);
    endtask
    // any strobe pattern held two cycles; returns the enables and data then seen
    task automatic strobe(input logic [3:0] c, output logic [15:0] oe, dv);
        bus_ctl = c;
        repeat (2) @(negedge mclk);
        oe = result_bus_oe;
        dv = result_bus_o;
        bus_ctl = 4'hC;
        repeat (2) @(negedge mclk);
    endtask
    // 50 ns needs two 40 ns cycles
    task automatic rst();
        dev_reset = 1'b1;
        repeat (2) @(negedge mclk);
        dev_reset = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
endmodule

/* File: verification/tb_adc_convert_and_port_control.sv */
// bench: host model, queue model of the result buffer, bound checker
// assumes acpc_host owns start, pin reset and strobes
`timescale 1ns/1ps
module tb_adc_convert_and_port_control;
    import acpc_pkg::*;
    logic mclk = 1'b0, rstn = 1'b0, standby_n = 1'b1, cfg_we = 1'b0;
    logic config_source_select = 1'b0, range_or_ext_clock = 1'b0, interface_select = 1'b0;
    logic [31:0] cfg_wdata = 32'h0000_0000, configuration_word;
    logic [15:0] core_result0 = 16'h0000, core_result1 = 16'h0000, d, hi, e, q[$];
    logic [15:0] result_bus_o, result_bus_oe;
    logic pair_a_convert_start, dev_reset, sample_pair_a, pair_a_ppd, busy, powered_down;
    logic range_4vref, ext_clock_sel;
    acpc_bus_ctl_t bus_ctl;
    int errors = 0, checks = 0;
    always #20 mclk = ~mclk;
    acpc_host host(.*);
    acpc_top acpc_top_inst(.*);
    task automatic chk(input logic [31:0] s, x);
        checks++;
        if (s !== x)
        begin
            errors++;
            $display("BAD %0t %h %h", $time, s, x);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // the model buffer holds two words; a third is dropped
    task automatic cv(input int h, input bit ok);
        core_result0 = 16'($urandom);
        host.conv(h);
        if (ok && q.size() < 2)
            q.push_back(core_result0);
    endtask
    task automatic rw();
        host.rd(1'b0, 1'b0, d);
        chk(32'(d), 32'(q.pop_front()));
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    initial
    begin
        #100_000;
        errors++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h3600));
        wt(16);
        rstn = 1'b1;
        wt(1);
        repeat (3) cv(24, 1);
        host.strobe(4'h4, e, d);
        chk(32'(e), 32'h0000_0000);
        host.strobe(4'h8, e, d);
        chk(32'(e), 32'h0000_0000);
        interface_select = 1'b1;
        host.strobe(4'h0, e, d);
        chk(32'(e), 32'h0000_0000);
        interface_select = 1'b0;
        host.strobe(4'h0, e, d);
        chk(32'(e), 32'h0000_FFFF);
        chk(32'(d), 32'(q.pop_front()));
        rw();
        $display("word done");
        for (int h = 0; h < 2; h++)
        begin
            cv(24, 1);
            e = q.pop_front();
            host.rd(1'b1, h[0], hi);
            host.rd(1'b1, h[0], d);
            chk({hi[15:8], d[15:8]}, h ? e : {e[7:0], e[15:8]});
        end
        $display("byte done");
        cv(6, 0);
        chk(32'(pair_a_ppd), 1);
        // pin reset in mid-conversion: nothing finishes, buffer is emptied
        fork
            host.conv(24);
            begin
                wt(8);
                chk(32'(busy), 1);
                host.rst();
                q.delete();
                chk(32'(busy), 0);
            end
        join
        chk(32'(busy), 0);
        chk(32'(pair_a_ppd), 0);
        config_source_select = 1'b1;
        cv(24, 0);
        cfg_wdata = 32'h0080_0800;
        cfg_we = 1'b1;
        wt(1);
        cfg_we = 1'b0;
        cv(24, 1);
        rw();
        chk(32'(ext_clock_sel), 1);
        host.rst();
        chk(configuration_word, CFG_RESET);
        $display("soft done");
        config_source_select = 1'b0;
        wt(4);
        chk(32'(range_4vref), 1);
        standby_n = 1'b0;
        wt(4);
        chk(32'(powered_down), 1);
        $display("pins done");
        end_of_test();
    end
endmodule
bind acpc_top acpc_checker acpc_checker_inst(.*);
